// ==== bench/general_output_pin_select_test.sv ====
// Self-checking bench for the output pin select block
`timescale 1ns/10ps
module general_output_pin_select_test;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, tempSenseEnable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic rxAboveThr, rxEmpty, rxPktEnd, rxOverflow, rxFlush, rxDiscard;
  logic rxCrcGood, rxFirstRead, txAboveThr, txFull, txUnderflow, txFlush;
  logic syncSeen, pktEnd, txMode, clearChannel, sleepMode;
  logic device_ready_low, chip_select_n, errv, pin1Valid;
  logic [2:0] pinOut, pinOe, pinSeen;
  int errTotal, testsRun;

  gos_output_select u_dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxAboveThr(rxAboveThr), .rxEmpty(rxEmpty), .rxPktEnd(rxPktEnd),
    .rxOverflow(rxOverflow), .rxFlush(rxFlush), .rxDiscard(rxDiscard),
    .rxCrcGood(rxCrcGood), .rxFirstRead(rxFirstRead),
    .txAboveThr(txAboveThr), .txFull(txFull), .txUnderflow(txUnderflow),
    .txFlush(txFlush), .syncSeen(syncSeen), .pktEnd(pktEnd),
    .txMode(txMode), .clearChannel(clearChannel), .sleepMode(sleepMode),
    .device_ready_low(device_ready_low), .chip_select_n(chip_select_n),
    .general_output_0(pinOut[0]), .general_output_0_oe(pinOe[0]),
    .general_output_1(pinOut[1]), .general_output_1_oe(pinOe[1]),
    .general_output_2(pinOut[2]), .general_output_2_oe(pinOe[2]),
    .tempSenseEnable(tempSenseEnable), .irq(irq));

  gos_host_model u_host (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .chip_select_n(chip_select_n), .pinSeen(pinSeen), .pin1Valid(pin1Valid));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task tallyAndFinish;
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tallyAndFinish

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Ends at a falling edge so outputs have settled
  task cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  // Request held until the edge where pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errTotal++;
      tallyAndFinish();
    end
  endtask : apb

  ////////////////////////////////////////////////////////////////////////
  task tReset;
    int n;
    logic v;
    apb(0, gos_pkg::ADDR_CFG0, 32'h0); chk("cfg0", rdv, 32'h3F);
    apb(0, gos_pkg::ADDR_CFG1, 32'h0); chk("cfg1", rdv, 32'h2E);
    apb(0, gos_pkg::ADDR_CFG2, 32'h0); chk("cfg2", rdv, 32'h29);
    chk("pin1 oe", pinOe[1], 1'b0);
    @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      v = pinOut[0]; n = 0;
      while (pinOut[0] === v && n < 300) begin @(negedge clk); n++; end
    end
    chk("pin0 half period", 32'(n), 32'd96);
    apb(0, 12'hFF0, 32'h0); chk("unmapped err", errv, 1'b1);
    $display("test reset done");
  endtask : tReset

  task tRxThr;
    apb(1, gos_pkg::ADDR_CFG2, 32'h00);
    @(posedge clk); rxAboveThr <= 1'b1;
    cyc(5); chk("rx thr pin", pinSeen[2], 1'b1);
    apb(1, gos_pkg::ADDR_CFG2, 32'h40);
    cyc(3); chk("rx thr inverted", pinSeen[2], 1'b0);
    apb(1, gos_pkg::ADDR_CFG2, 32'h02);
    @(posedge clk); txAboveThr <= 1'b1;
    cyc(5); chk("tx thr pin", pinSeen[2], 1'b1);
    @(posedge clk); txAboveThr <= 1'b0;
    cyc(5); chk("tx thr low", pinSeen[2], 1'b0);
    $display("test threshold done");
  endtask : tRxThr

  task tOverflow;
    apb(1, gos_pkg::ADDR_CFG2, 32'h04);
    apb(1, gos_pkg::ADDR_MASK, 32'h1);
    @(posedge clk); rxOverflow <= 1'b1;
    repeat (2) @(posedge clk); rxOverflow <= 1'b0;
    cyc(8); chk("ovf held", pinSeen[2], 1'b1);
    chk("irq set", irq, 1'b1);
    apb(1, gos_pkg::ADDR_IRQ, 32'h1);
    cyc(2); chk("irq cleared", irq, 1'b0);
    @(posedge clk); rxFlush <= 1'b1;
    repeat (2) @(posedge clk); rxFlush <= 1'b0;
    cyc(6); chk("ovf flushed", pinSeen[2], 1'b0);
    $display("test overflow done");
  endtask : tOverflow

  task tSleep;
    apb(1, gos_pkg::ADDR_CFG0, 32'h00);
    apb(1, gos_pkg::ADDR_CFG1, 32'h00);
    apb(1, gos_pkg::ADDR_CFG2, 32'h40);
    @(posedge clk); device_ready_low <= 1'b1; sleepMode <= 1'b1;
    cyc(6);
    chk("sleep pin0", pinSeen[0], 1'b0);
    chk("sleep pin1", pinSeen[1], 1'b1);
    chk("sleep pin2", pinSeen[2], 1'b1);
    @(posedge clk); sleepMode <= 1'b0;
    cyc(6); chk("sleep held", pinSeen[2], 1'b1);
    @(posedge clk); device_ready_low <= 1'b0;
    cyc(6); chk("sleep released", pinSeen[2], 1'b0);
    $display("test sleep done");
  endtask : tSleep

  task tPins;
    apb(1, gos_pkg::ADDR_CFG1, 32'h2E);
    cyc(3); chk("pin1 hiz", pinOe[1], 1'b0);
    apb(1, gos_pkg::ADDR_CFG0, 32'h80);
    cyc(3); chk("temp enable", tempSenseEnable, 1'b1);
    chk("temp pin0 oe", pinOe[0], 1'b0);
    $display("test pins done");
  endtask : tPins

  // Chip select low releases pin 1; clear channel shown inverted on pin 2
  task tSerial;
    apb(1, gos_pkg::ADDR_CFG1, 32'h00);
    apb(1, gos_pkg::ADDR_CFG2, 32'h49);
    @(posedge clk);
    chip_select_n <= 1'b0;
    clearChannel  <= 1'b1;
    cyc(5);
    chk("cs pin1 oe", pinOe[1], 1'b0);
    chk("cs pin1 valid", pin1Valid, 1'b0);
    chk("cca inverted", pinSeen[2], 1'b0);
    @(posedge clk);
    chip_select_n <= 1'b1;
    clearChannel  <= 1'b0;
    cyc(5);
    chk("idle pin1 oe", pinOe[1], 1'b1);
    chk("idle pin1 level", pinSeen[1], 1'b1);
    chk("cca idle", pinSeen[2], 1'b1);
    $display("test serial done");
  endtask : tSerial

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, rxAboveThr, rxEmpty, rxPktEnd, rxOverflow} = 0;
    {rxFlush, rxDiscard, rxCrcGood, rxFirstRead, txAboveThr, txFull} = 0;
    {txUnderflow, txFlush, syncSeen, pktEnd, txMode, clearChannel} = 0;
    {sleepMode, device_ready_low} = 0;
    chip_select_n = 1'b1; paddr = 12'h000; pwdata = 32'h0;
    errTotal = 0; testsRun = 0; nrst = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tReset; tRxThr; tOverflow; tSleep; tSerial; tPins;
    tallyAndFinish();
  end

  initial begin
    repeat (50000) @(posedge clk);
    errTotal++;
    tallyAndFinish();
  end
endmodule : general_output_pin_select_test

// ==== bench/gos_host_model.sv ====
// Host model sampling the three output pins
`timescale 1ns/10ps
module gos_host_model (
  // Clock
  input  wire logic       clk,
  // Pins and enables
  input  wire logic [2:0] pinOut,
  input  wire logic [2:0] pinOe,
  input  wire logic       chip_select_n,
  // Levels seen by the host
  output logic      [2:0] pinSeen,
  output logic            pin1Valid
);
  logic [2:0] lastLevel = 3'h0;
  logic [2:0] wireLevel;

  // Released pin floats: show inverse of last sampled level, so it toggles every cycle
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      wireLevel[i] = pinOe[i] ? pinOut[i] : ~lastLevel[i];
    end
  end

  always @(posedge clk) begin
    lastLevel <= wireLevel;
    pinSeen   <= wireLevel;
    pin1Valid <= chip_select_n;
  end
endmodule : gos_host_model

// ==== shared/gos_pkg.sv ====
// Constants for the general output pin select block
//
// Contract
// - Three output pins, each with an independent rewritable 6-bit source select.
// - Pin 1 shares serial out; its function is valid only while chip select high.
// - After reset pin 1 is high impedance.
// - After reset pin 0 carries the oscillator clock divided by 192.
// - Writing 0x80 to pin 0 configuration routes the temperature sensor analog.
// - In sleep with select below 0x20, pins 0/2 show invert, pin 1 its complement.
// - Forced sleep levels hold until device ready low goes low.
// - Select 0x20 or above keeps its function during sleep.
// - Select 0x2E on pin 1 gives high impedance in every state.
// - Code 0x00 high while receive fill at or above threshold.
// - Code 0x01 sets on receive threshold or packet end, clears on receive empty.
// - Code 0x02 high while transmit fill at or above threshold.
// - Code 0x03 sets on transmit full, clears below transmit threshold.
// - Code 0x04 sets on receive overflow, clears on receive flush.
// - Code 0x05 sets on transmit underflow, clears on transmit flush.
// - Code 0x06 sync to packet end; also ends on discard or overflow in receive, underflow in transmit.
// - Code 0x07 sets on good-CRC packet, clears on first receive byte read.
// - Code 0x09 shows clear channel indication.
package gos_pkg;

  localparam int          SEL_W       = 6;
  localparam int          CFG_W       = 8;
  localparam int          NUM_PINS    = 3;
  localparam int          CLK_DIV     = 192;
  localparam logic [7:0]  CFG0_RESET  = 8'h3F;
  localparam logic [7:0]  CFG1_RESET  = 8'h2E;
  localparam logic [7:0]  CFG2_RESET  = 8'h29;
  localparam logic [7:0]  TEMP_SENSE  = 8'h80;
  localparam int          INV_BIT     = 6;
  localparam int          TEMP_BIT    = 7;
  localparam logic [5:0]  SLEEP_LIMIT = 6'h20;

  localparam logic [5:0]  SEL_RX_THR   = 6'h00;
  localparam logic [5:0]  SEL_RX_PKT   = 6'h01;
  localparam logic [5:0]  SEL_TX_THR   = 6'h02;
  localparam logic [5:0]  SEL_TX_FULL  = 6'h03;
  localparam logic [5:0]  SEL_RX_OVF   = 6'h04;
  localparam logic [5:0]  SEL_TX_UNF   = 6'h05;
  localparam logic [5:0]  SEL_SYNC     = 6'h06;
  localparam logic [5:0]  SEL_CRC_OK   = 6'h07;
  localparam logic [5:0]  SEL_CCA      = 6'h09;
  localparam logic [5:0]  SEL_HIZ      = 6'h2E;
  localparam logic [5:0]  SEL_CLK_DIV  = 6'h3F;

  localparam logic [11:0] ADDR_CFG0    = 12'h000;
  localparam logic [11:0] ADDR_CFG1    = 12'h004;
  localparam logic [11:0] ADDR_CFG2    = 12'h008;
  localparam logic [11:0] ADDR_STATUS  = 12'h00C;
  localparam logic [11:0] ADDR_IRQ     = 12'h010;
  localparam logic [11:0] ADDR_MASK    = 12'h014;

  localparam int          IRQ_W        = 4;
  localparam int          IRQ_RX_OVF   = 0;
  localparam int          IRQ_TX_UNF   = 1;
  localparam int          IRQ_CRC_OK   = 2;
  localparam int          IRQ_SYNC     = 3;

endpackage : gos_pkg

// ==== src/gos_clock_divider.sv ====
// Clock divider producing the slow output clock
`timescale 1ns/10ps
module gos_clock_divider #(
  parameter int DIVIDE = gos_pkg::CLK_DIV
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Divided clock
  output logic      divClk
);

  typedef struct packed {
    logic [7:0] count;
    logic       level;
  } gos_div_state_type;

  localparam logic [7:0] HALF = 8'((DIVIDE / 2) - 1);

  gos_div_state_type state_reg;
  gos_div_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (state_reg.count == HALF) begin
      state_next.count = 8'h00;
      state_next.level = ~state_reg.level;
    end else begin
      state_next.count = state_reg.count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign divClk = state_reg.level;

  AST_DIV_HALF_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
    $changed(state_reg.level) |-> $past(state_reg.count) == HALF)
    else $error("divider toggled at wrong count");

endmodule : gos_clock_divider

// ==== src/gos_output_select.sv ====
// General output pin select with APB registers and interrupt
`timescale 1ns/10ps
module gos_output_select (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Radio status sources
  input  wire logic        rxAboveThr,
  input  wire logic        rxEmpty,
  input  wire logic        rxPktEnd,
  input  wire logic        rxOverflow,
  input  wire logic        rxFlush,
  input  wire logic        rxDiscard,
  input  wire logic        rxCrcGood,
  input  wire logic        rxFirstRead,
  input  wire logic        txAboveThr,
  input  wire logic        txFull,
  input  wire logic        txUnderflow,
  input  wire logic        txFlush,
  input  wire logic        syncSeen,
  input  wire logic        pktEnd,
  input  wire logic        txMode,
  input  wire logic        clearChannel,
  // Power state and chip select
  input  wire logic        sleepMode,
  input  wire logic        device_ready_low,
  input  wire logic        chip_select_n,
  // Output pins
  output logic             general_output_0,
  output logic             general_output_0_oe,
  output logic             general_output_1,
  output logic             general_output_1_oe,
  output logic             general_output_2,
  output logic             general_output_2_oe,
  output logic             tempSenseEnable,
  output logic             irq
);

  localparam int N = gos_pkg::NUM_PINS;
  localparam int NS = 16;

  typedef struct packed {
    logic [N-1:0][7:0]            cfg;
    logic [1:0][NS-1:0]           sync;
    logic [1:0][2:0]              pwr;
    logic                         rxPktLatch;
    logic                         txFullLatch;
    logic                         rxOvfLatch;
    logic                         txUnfLatch;
    logic                         syncWin;
    logic                         crcLatch;
    logic                         forced;
    logic [NS-1:0]                srcPrev;
    logic [gos_pkg::IRQ_W-1:0]    status;
    logic [gos_pkg::IRQ_W-1:0]    mask;
    logic [31:0]                  rdata;
    logic                         ready;
    logic                         err;
    logic [N-1:0]                 pin;
    logic [N-1:0]                 oe;
    logic                         temp;
    logic                         irq;
  } gos_state_type;

  gos_state_type state_reg;
  gos_state_type state_next;

  logic          divClk;
  logic [NS-1:0] rawIn;
  logic [NS-1:0] syncIn;

  gos_clock_divider #(
    .DIVIDE (gos_pkg::CLK_DIV)
  ) u_div (
    .clk    (clk),
    .nrst   (nrst),
    .divClk (divClk)
  );

  assign rawIn = {rxAboveThr, rxEmpty, rxPktEnd, rxOverflow, rxFlush,
                  rxDiscard, rxCrcGood, rxFirstRead, txAboveThr, txFull,
                  txUnderflow, txFlush, syncSeen, pktEnd, txMode,
                  clearChannel};
  assign syncIn = state_reg.sync[1];

  // Named views of synchronised inputs
  logic sRxThr, sRxEmpty, sRxPkt, sRxOvf, sRxFlush, sRxDisc, sCrc, sFirst;
  logic sTxThr, sTxFull, sTxUnf, sTxFlush, sSync, sPktEnd, sTxMode, sCca;
  assign {sRxThr, sRxEmpty, sRxPkt, sRxOvf, sRxFlush, sRxDisc, sCrc, sFirst,
          sTxThr, sTxFull, sTxUnf, sTxFlush, sSync, sPktEnd, sTxMode,
          sCca} = syncIn;

  logic       sleepS;
  logic       readyLowS;
  logic       csnS;
  assign {sleepS, readyLowS, csnS} = state_reg.pwr[1];

  // Source value of one select code
  function automatic logic srcOf(input logic [5:0] sel,
                                 input gos_state_type s,
                                 input logic clkIn);
    logic v;
    v = 1'b0;
    case (sel)
      gos_pkg::SEL_RX_THR:  v = sRxThr;
      gos_pkg::SEL_RX_PKT:  v = s.rxPktLatch;
      gos_pkg::SEL_TX_THR:  v = sTxThr;
      gos_pkg::SEL_TX_FULL: v = s.txFullLatch;
      gos_pkg::SEL_RX_OVF:  v = s.rxOvfLatch;
      gos_pkg::SEL_TX_UNF:  v = s.txUnfLatch;
      gos_pkg::SEL_SYNC:    v = s.syncWin;
      gos_pkg::SEL_CRC_OK:  v = s.crcLatch;
      gos_pkg::SEL_CCA:     v = sCca;
      gos_pkg::SEL_CLK_DIV: v = clkIn;
      default:              v = 1'b0;
    endcase
    return v;
  endfunction : srcOf

  logic busWrite;
  logic busRead;
  assign busWrite = psel && penable && pwrite && state_reg.ready;
  assign busRead  = psel && !penable && !pwrite;

  always_comb begin
    logic [gos_pkg::IRQ_W-1:0] ev;
    logic [5:0]                sel;
    logic                      inv;
    logic                      v;
    ev  = '0;
    sel = '0;
    inv = 1'b0;
    v   = 1'b0;
    state_next = state_reg;
    state_next.sync[0] = rawIn;
    state_next.sync[1] = state_reg.sync[0];
    state_next.pwr[0]  = {sleepMode, device_ready_low, chip_select_n};
    state_next.pwr[1]  = state_reg.pwr[0];
    state_next.srcPrev = syncIn;

    // Sticky source latches
    if (sRxThr || sRxPkt) begin
      state_next.rxPktLatch = 1'b1;
    end else if (sRxEmpty) begin
      state_next.rxPktLatch = 1'b0;
    end
    if (sTxFull) begin
      state_next.txFullLatch = 1'b1;
    end else if (!sTxThr) begin
      state_next.txFullLatch = 1'b0;
    end
    if (sRxOvf) begin
      state_next.rxOvfLatch = 1'b1;
    end else if (sRxFlush) begin
      state_next.rxOvfLatch = 1'b0;
    end
    if (sTxUnf) begin
      state_next.txUnfLatch = 1'b1;
    end else if (sTxFlush) begin
      state_next.txUnfLatch = 1'b0;
    end
    if (sPktEnd || (!sTxMode && (sRxDisc || sRxOvf))
        || (sTxMode && sTxUnf)) begin
      state_next.syncWin = 1'b0;
    end else if (sSync) begin
      state_next.syncWin = 1'b1;
    end
    if (sCrc) begin
      state_next.crcLatch = 1'b1;
    end else if (sFirst) begin
      state_next.crcLatch = 1'b0;
    end

    // Sleep forcing held until ready indication falls
    if (sleepS) begin
      state_next.forced = 1'b1;
    end else if (!readyLowS) begin
      state_next.forced = 1'b0;
    end

    // Interrupt events, set wins over clear
    ev[gos_pkg::IRQ_RX_OVF] = sRxOvf && !state_reg.srcPrev[12];
    ev[gos_pkg::IRQ_TX_UNF] = sTxUnf && !state_reg.srcPrev[5];
    ev[gos_pkg::IRQ_CRC_OK] = sCrc && !state_reg.srcPrev[9];
    ev[gos_pkg::IRQ_SYNC]   = sSync && !state_reg.srcPrev[3];

    // APB access
    state_next.ready = psel && !penable;
    state_next.err   = 1'b0;
    if (busRead) begin
      if (paddr == gos_pkg::ADDR_CFG0) begin
        state_next.rdata = {24'h000000, state_reg.cfg[0]};
      end else if (paddr == gos_pkg::ADDR_CFG1) begin
        state_next.rdata = {24'h000000, state_reg.cfg[1]};
      end else if (paddr == gos_pkg::ADDR_CFG2) begin
        state_next.rdata = {24'h000000, state_reg.cfg[2]};
      end else if (paddr == gos_pkg::ADDR_STATUS) begin
        state_next.rdata = {16'h0000, syncIn};
      end else if (paddr == gos_pkg::ADDR_IRQ) begin
        state_next.rdata = {28'h0000000, state_reg.status};
      end else if (paddr == gos_pkg::ADDR_MASK) begin
        state_next.rdata = {28'h0000000, state_reg.mask};
      end else begin
        state_next.rdata = 32'h00000000;
        state_next.err   = 1'b1;
      end
    end else if (psel && !penable) begin
      state_next.rdata = 32'h00000000;
      state_next.err   = !(paddr == gos_pkg::ADDR_CFG0
                        || paddr == gos_pkg::ADDR_CFG1
                        || paddr == gos_pkg::ADDR_CFG2
                        || paddr == gos_pkg::ADDR_STATUS
                        || paddr == gos_pkg::ADDR_IRQ
                        || paddr == gos_pkg::ADDR_MASK);
    end
    if (penable && state_reg.ready) begin
      state_next.err = state_reg.err;
    end
    if (busWrite) begin
      if (paddr == gos_pkg::ADDR_CFG0) begin
        state_next.cfg[0] = pwdata[7:0];
      end else if (paddr == gos_pkg::ADDR_CFG1) begin
        state_next.cfg[1] = pwdata[7:0];
      end else if (paddr == gos_pkg::ADDR_CFG2) begin
        state_next.cfg[2] = pwdata[7:0];
      end else if (paddr == gos_pkg::ADDR_IRQ) begin
        state_next.status = state_reg.status & ~pwdata[3:0];
      end else if (paddr == gos_pkg::ADDR_MASK) begin
        state_next.mask = pwdata[3:0];
      end
    end
    state_next.status = state_next.status | ev;

    // Pin multiplexing
    for (int i = 0; i < N; i++) begin
      sel = state_next.cfg[i][5:0];
      inv = state_next.cfg[i][gos_pkg::INV_BIT];
      v   = srcOf(sel, state_next, divClk) ^ inv;
      state_next.oe[i] = 1'b1;
      if (state_next.forced && sel < gos_pkg::SLEEP_LIMIT) begin
        v = (i == 1) ? ~inv : inv;
      end
      if (i == 1 && sel == gos_pkg::SEL_HIZ) begin
        state_next.oe[i] = 1'b0;
      end
      if (i == 1 && !csnS) begin
        state_next.oe[i] = 1'b0;
      end
      state_next.pin[i] = v;
    end
    state_next.temp = state_next.cfg[0] == gos_pkg::TEMP_SENSE;
    if (state_next.temp) begin
      state_next.oe[0] = 1'b0;
    end
    state_next.irq = |(state_next.status & state_next.mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg        <= '0;
      state_reg.cfg[0] <= gos_pkg::CFG0_RESET;
      state_reg.cfg[1] <= gos_pkg::CFG1_RESET;
      state_reg.cfg[2] <= gos_pkg::CFG2_RESET;
      state_reg.oe     <= 3'h5;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata              = state_reg.rdata;
  assign pready              = state_reg.ready;
  assign pslverr             = state_reg.err;
  assign general_output_0    = state_reg.pin[0];
  assign general_output_0_oe = state_reg.oe[0];
  assign general_output_1    = state_reg.pin[1];
  assign general_output_1_oe = state_reg.oe[1];
  assign general_output_2    = state_reg.pin[2];
  assign general_output_2_oe = state_reg.oe[2];
  assign tempSenseEnable     = state_reg.temp;
  assign irq                 = state_reg.irq;

  AST_HIZ_PIN1: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.cfg[1][5:0] == gos_pkg::SEL_HIZ |-> !general_output_1_oe)
    else $error("pin 1 driven while high impedance selected");
  AST_CS_PIN1: assert property (@(posedge clk) disable iff (!nrst)
    !csnS |=> !general_output_1_oe)
    else $error("pin 1 driven during serial transfer");
  AST_SLEEP_P0: assert property (@(posedge clk) disable iff (!nrst)
    state_next.forced && state_next.cfg[0][5:0] < gos_pkg::SLEEP_LIMIT
    |=> general_output_0 == state_reg.cfg[0][gos_pkg::INV_BIT])
    else $error("pin 0 not forced in sleep");
  AST_SLEEP_P1: assert property (@(posedge clk) disable iff (!nrst)
    state_next.forced && state_next.cfg[1][5:0] < gos_pkg::SLEEP_LIMIT
    |=> general_output_1 != state_reg.cfg[1][gos_pkg::INV_BIT])
    else $error("pin 1 not forced in sleep");
  AST_FORCE_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.forced && !sleepS && readyLowS |=> state_reg.forced)
    else $error("forcing released early");
  AST_RX_THR: assert property (@(posedge clk) disable iff (!nrst)
    !state_next.forced && state_next.cfg[2] == 8'h00
    |=> general_output_2 == $past(sRxThr))
    else $error("rx threshold not shown");
  AST_OVF_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.rxOvfLatch && !sRxFlush |=> state_reg.rxOvfLatch)
    else $error("overflow latch dropped");
  AST_UNF_SET: assert property (@(posedge clk) disable iff (!nrst)
    sTxUnf |=> state_reg.txUnfLatch)
    else $error("underflow not latched");
  AST_TXFULL: assert property (@(posedge clk) disable iff (!nrst)
    sTxFull |=> state_reg.txFullLatch ##1 1'b1)
    else $error("tx full not latched");
  AST_CRC: assert property (@(posedge clk) disable iff (!nrst)
    sFirst && !sCrc |=> !state_reg.crcLatch)
    else $error("crc flag not cleared by read");
  AST_INV: assert property (@(posedge clk) disable iff (!nrst)
    !state_next.forced && state_next.cfg[2] == 8'h49
    |=> general_output_2 == !$past(sCca))
    else $error("inverted clear channel wrong");
  AST_TEMP: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.cfg[0] == gos_pkg::TEMP_SENSE |-> tempSenseEnable
    && !general_output_0_oe)
    else $error("temperature path not routed");
  AST_SYNC_END: assert property (@(posedge clk) disable iff (!nrst)
    sPktEnd |=> !state_reg.syncWin)
    else $error("sync window not closed");
  AST_PKT: assert property (@(posedge clk) disable iff (!nrst)
    sRxPkt |=> state_reg.rxPktLatch)
    else $error("packet end not latched");
  AST_TX_THR: assert property (@(posedge clk) disable iff (!nrst)
    !state_next.forced && state_next.cfg[2] == 8'h02
    |=> general_output_2 == $past(sTxThr))
    else $error("tx threshold not shown");
  AST_CFG_WR: assert property (@(posedge clk) disable iff (!nrst)
    busWrite && paddr == gos_pkg::ADDR_CFG2
    |=> state_reg.cfg[2] == $past(pwdata[7:0]))
    else $error("select write lost");
  AST_AWAKE: assert property (@(posedge clk) disable iff (!nrst)
    state_next.cfg[0][5:0] >= gos_pkg::SLEEP_LIMIT
    && !state_next.temp |=> general_output_0_oe)
    else $error("pin 0 not driven");

  COV_SLEEP: cover property (@(posedge clk) disable iff (!nrst)
    state_reg.forced ##1 !state_reg.forced);
  COV_IRQ: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
  COV_WRITE: cover property (@(posedge clk) disable iff (!nrst) busWrite);
  COV_ERR: cover property (@(posedge clk) disable iff (!nrst)
    pready && pslverr);

endmodule : gos_output_select
